//--- rtl/pmcr_consts.vh
// Constants for the power capability word readback block.
`ifndef PMCR_CONSTS_VH
`define PMCR_CONSTS_VH

// Word placement inside the capability structure (byte offset from its base).
`define PMCR_CAP_WORD_OFFSET   8'h02

// Field positions of the capability word.
`define PMCR_WAKE_MSB          15
`define PMCR_WAKE_LSB          11
`define PMCR_COLD_WAKE_BIT     15
`define PMCR_D2_BIT            10
`define PMCR_D1_BIT            9
`define PMCR_AUX_MSB           8
`define PMCR_AUX_LSB           6
`define PMCR_DEV_INIT_BIT      5
`define PMCR_RSVD_BIT          4
`define PMCR_CLK_DEP_BIT       3
`define PMCR_REV_MSB           2
`define PMCR_REV_LSB           0

// Fixed field values.
`define PMCR_REV_CODE          3'h2
`define PMCR_RSVD_VALUE        1'h0
`define PMCR_AUX_ZERO          3'h0

// Auxiliary current codes and their maximum draw in mA.
`define PMCR_AUX_SELF          3'h0
`define PMCR_AUX_55MA          3'h1
`define PMCR_AUX_100MA         3'h2
`define PMCR_AUX_160MA         3'h3
`define PMCR_AUX_220MA         3'h4
`define PMCR_AUX_270MA         3'h5
`define PMCR_AUX_320MA         3'h6
`define PMCR_AUX_375MA         3'h7
`define PMCR_MA_55             55
`define PMCR_MA_100            100
`define PMCR_MA_160            160
`define PMCR_MA_220            220
`define PMCR_MA_270            270
`define PMCR_MA_320            320

// Reset values.
`define PMCR_WORD_RESET        16'h0000
`define PMCR_STRAP_RESET       1'h0

// Cycles after reset release before the strap is caught (synchroniser fill).
`define PMCR_STRAP_SETTLE      2'h3

`endif

//--- rtl/pmcr_sync.v
// Two flip-flop level synchroniser with clock enable.
module pmcr_sync (
	// Clock, reset and enable.
	input  wire CLK,
	input  wire RESETN,
	input  wire CE,
	// Asynchronous level in, synchronised level out.
	input  wire D_ASYNC,
	output wire Q_SYNC
);

	reg meta_reg;
	reg sync_reg;

	// The first stage feeds only the second stage, so a metastable value never fans out.
	always @(posedge CLK) begin
		if (!RESETN) begin
			meta_reg <= 1'h0;
			sync_reg <= 1'h0;
		end else if (CE) begin
			meta_reg <= D_ASYNC;
			sync_reg <= meta_reg;
		end
	end

	assign Q_SYNC = sync_reg;

endmodule

//--- rtl/pmcr_top.v
// Power capability word readback over a configuration read port.
`include "pmcr_consts.vh"

// Operation
// - Bits 8 to 6 report the auxiliary standby current requirement, read-only.
// - With a power data register present the current field reads 000b.
// - Without cold-off wake capability the current field reads 000b.
// - Otherwise the current field encodes maximum draw, 55 to 375 mA or self powered.
// - Bit 5 reads 1 when device-specific initialisation is needed after uninitialised D0.
// - Bit 3 reads 1 when wake signalling needs the bus clock running.
// - Bit 3 reads 0 when wake signalling is impossible in every power state.
// - Bits 2 to 0 always read the revision code 010b.
// - The cold-wake strap sampled at power-on sets bit 15.
// - The word is read-only, sixteen bits, two bytes above the capability base.
// - Bits 11 to 15 flag wake capability from D0, D1, D2, D3hot, D3cold.
module pmcr_top #(
	parameter [7:0] CAP_BASE        = 8'h40,
	parameter [3:0] WAKE_LOW_STATES = 4'h0,
	parameter [0:0] D1_SUPPORT      = 1'h0,
	parameter [0:0] D2_SUPPORT      = 1'h0,
	parameter       AUX_MAX_MA      = 0,
	parameter [0:0] DATA_REG_IMPL   = 1'h0,
	parameter [0:0] DEV_INIT_REQ    = 1'h0,
	parameter [0:0] WAKE_NEEDS_CLK  = 1'h0
) (
	// Clock, reset and enable.
	input  wire        CLK,
	input  wire        RESETN,
	input  wire        CE,
	// Power-on strap pin.
	input  wire        COLD_WAKE_STRAP_PIN,
	// Configuration access port.
	input  wire        CFG_RD,
	input  wire        CFG_WR,
	input  wire [7:0]  CFG_ADDR,
	input  wire [15:0] CFG_WDATA,
	output reg  [15:0] CFG_RDATA,
	output reg         CFG_ACK,
	// Status.
	output reg         WAKE_FROM_COLD_CAPABLE,
	output reg         STRAP_VALID
);

	////////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Map the worst-case standby draw in mA onto the smallest code that covers it.
	function [2:0] aux_code_for;
		input integer ma;
		begin
			if (ma <= 0)
				aux_code_for = `PMCR_AUX_SELF;
			else if (ma <= `PMCR_MA_55)
				aux_code_for = `PMCR_AUX_55MA;
			else if (ma <= `PMCR_MA_100)
				aux_code_for = `PMCR_AUX_100MA;
			else if (ma <= `PMCR_MA_160)
				aux_code_for = `PMCR_AUX_160MA;
			else if (ma <= `PMCR_MA_220)
				aux_code_for = `PMCR_AUX_220MA;
			else if (ma <= `PMCR_MA_270)
				aux_code_for = `PMCR_AUX_270MA;
			else if (ma <= `PMCR_MA_320)
				aux_code_for = `PMCR_AUX_320MA;
			else
				aux_code_for = `PMCR_AUX_375MA;
		end
	endfunction

	// True when the byte address falls in the capability word (either of its bytes).
	function addr_hits_word;
		input [7:0] addr;
		reg   [7:0] word_addr;
		begin
			word_addr      = CAP_BASE + `PMCR_CAP_WORD_OFFSET;
			addr_hits_word = (addr[7:1] == word_addr[7:1]);
		end
	endfunction

	localparam [2:0] AUX_CODE = aux_code_for(AUX_MAX_MA);

	////////////////////////////////////////////////////////////////////////////////
	// Strap capture.

	wire       strap_sync;
	reg  [1:0] settle_reg;
	reg  [1:0] settle_next;
	reg        strap_valid_next;
	reg        cold_wake_reg;
	reg        cold_wake_next;

	// The pin is outside the clock domain, so it is synchronised before use.
	pmcr_sync u_strap_sync (
		.CLK     (CLK),
		.RESETN  (RESETN),
		.CE      (CE),
		.D_ASYNC (COLD_WAKE_STRAP_PIN),
		.Q_SYNC  (strap_sync)
	);

	// Wait for the synchroniser to fill after release, then latch the strap once.
	// It is held until the next reset, so later pin changes have no effect.
	always @* begin
		settle_next      = settle_reg;
		strap_valid_next = STRAP_VALID;
		cold_wake_next   = cold_wake_reg;
		if (!STRAP_VALID) begin
			if (settle_reg == `PMCR_STRAP_SETTLE) begin
				strap_valid_next = 1'h1;
				cold_wake_next   = strap_sync;
			end else begin
				settle_next = settle_reg + 2'h1;
			end
		end
	end

	always @(posedge CLK) begin
		if (!RESETN) begin
			settle_reg    <= 2'h0;
			STRAP_VALID   <= 1'h0;
			cold_wake_reg <= `PMCR_STRAP_RESET;
		end else if (CE) begin
			settle_reg    <= settle_next;
			STRAP_VALID   <= strap_valid_next;
			cold_wake_reg <= cold_wake_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Capability word composition.

	wire [4:0] wake_states;
	wire       any_wake;
	reg  [2:0] aux_field;
	wire       clk_dep_field;
	wire [15:0] cap_word;

	// The cold-off bit comes from the strap, the lower four from the build.
	assign wake_states = {cold_wake_reg, WAKE_LOW_STATES};
	assign any_wake    = |wake_states;

	// The data register takes over current reporting, and without cold-off wake
	// there is no standby draw to report, so both force the field to zero.
	always @* begin
		if (DATA_REG_IMPL)
			aux_field = `PMCR_AUX_ZERO;
		else if (!cold_wake_reg)
			aux_field = `PMCR_AUX_ZERO;
		else
			aux_field = AUX_CODE;
	end

	// A clock dependency means nothing when no state can wake.
	assign clk_dep_field = WAKE_NEEDS_CLK & any_wake;

	// Assemble the sixteen bits in their documented places.
	assign cap_word[`PMCR_WAKE_MSB:`PMCR_WAKE_LSB] = wake_states;
	assign cap_word[`PMCR_D2_BIT]                  = D2_SUPPORT;
	assign cap_word[`PMCR_D1_BIT]                  = D1_SUPPORT;
	assign cap_word[`PMCR_AUX_MSB:`PMCR_AUX_LSB]   = aux_field;
	assign cap_word[`PMCR_DEV_INIT_BIT]            = DEV_INIT_REQ;
	assign cap_word[`PMCR_RSVD_BIT]                = `PMCR_RSVD_VALUE;
	assign cap_word[`PMCR_CLK_DEP_BIT]             = clk_dep_field;
	assign cap_word[`PMCR_REV_MSB:`PMCR_REV_LSB]   = `PMCR_REV_CODE;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration access.

	reg [15:0] rdata_next;
	reg        ack_next;

	// A read of the word returns it one cycle later; other addresses read zero.
	// Writes are acknowledged but change nothing, since every bit is read-only.
	always @* begin
		rdata_next = `PMCR_WORD_RESET;
		ack_next   = 1'h0;
		if (CFG_RD) begin
			ack_next = 1'h1;
			if (addr_hits_word(CFG_ADDR))
				rdata_next = cap_word;
		end else if (CFG_WR) begin
			ack_next = 1'h1;
		end
	end

	// Registered answer keeps every output straight from a flip-flop.
	always @(posedge CLK) begin
		if (!RESETN) begin
			CFG_RDATA              <= `PMCR_WORD_RESET;
			CFG_ACK                <= 1'h0;
			WAKE_FROM_COLD_CAPABLE <= `PMCR_STRAP_RESET;
		end else if (CE) begin
			CFG_RDATA              <= rdata_next;
			CFG_ACK                <= ack_next;
			WAKE_FROM_COLD_CAPABLE <= cold_wake_reg;
		end
	end

	// Write data is deliberately unused: no bit of this word may be written.
	wire unused_wdata = |CFG_WDATA;

endmodule

//--- tb/pmcr_asserts.sv
// Port checker for the power capability word readback block.
module pmcr_asserts (
	// Clock, reset, enable and power-on strap pin.
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic        CE,
	input wire logic        COLD_WAKE_STRAP_PIN,
	// Configuration port.
	input wire logic        CFG_RD,
	input wire logic        CFG_WR,
	input wire logic [7:0]  CFG_ADDR,
	input wire logic [15:0] CFG_RDATA,
	input wire logic        CFG_ACK,
	// Status.
	input wire logic        WAKE_FROM_COLD_CAPABLE,
	input wire logic        STRAP_VALID
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	////////////////////////////////////////////////////////////////////////////
	// A read of the capability word at its default base plus two.
	sequence s_cap_rd; CE && CFG_RD && CFG_ADDR[7:1] == 7'h21; endsequence
	sequence s_take; CE && (CFG_RD || CFG_WR); endsequence
	property p_ack; s_take |=> CFG_ACK; endproperty
	a_ack: assert property (p_ack) else $error("request without answer");
	// A frozen cycle keeps the last answer, so only enabled idle cycles must drop it.
	property p_no_ack; CE && !CFG_RD && !CFG_WR |=> !CFG_ACK; endproperty
	a_no_ack: assert property (p_no_ack) else $error("answer without request");
	property p_hold; !CE |=> $stable(CFG_ACK) && $stable(CFG_RDATA); endproperty
	a_hold: assert property (p_hold) else $error("answer moved while frozen");
	property p_rev; s_cap_rd |=> CFG_RDATA[2:0] == 3'h2; endproperty
	a_rev: assert property (p_rev) else $error("revision code wrong");
	property p_rsvd; s_cap_rd |=> !CFG_RDATA[4]; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_aux; s_cap_rd |=> CFG_RDATA[15] || CFG_RDATA[8:6] == 3'h0; endproperty
	a_aux: assert property (p_aux) else $error("current field without cold wake");
	property p_clk; s_cap_rd |=> (|CFG_RDATA[15:11]) || !CFG_RDATA[3]; endproperty
	a_clk: assert property (p_clk) else $error("clock flag without wake");
	property p_wr; CE && CFG_WR && !CFG_RD |=> CFG_RDATA == 16'h0000; endproperty
	a_wr: assert property (p_wr) else $error("write returned data");
	// The strap is caught only once the synchroniser has filled.
	property p_cap; $rose(RESETN) |-> !STRAP_VALID[*3] ##[1:2] STRAP_VALID; endproperty
	a_cap: assert property (p_cap) else $error("strap capture timing");
	property p_pin; STRAP_VALID && $past(STRAP_VALID) |-> WAKE_FROM_COLD_CAPABLE == COLD_WAKE_STRAP_PIN; endproperty
	a_pin: assert property (p_pin) else $error("strap level lost");
endmodule

bind pmcr_top pmcr_asserts chk_u (.CLK(CLK), .RESETN(RESETN), .CE(CE),
	.COLD_WAKE_STRAP_PIN(COLD_WAKE_STRAP_PIN), .CFG_RD(CFG_RD), .CFG_WR(CFG_WR),
	.CFG_ADDR(CFG_ADDR), .CFG_RDATA(CFG_RDATA), .CFG_ACK(CFG_ACK),
	.WAKE_FROM_COLD_CAPABLE(WAKE_FROM_COLD_CAPABLE), .STRAP_VALID(STRAP_VALID));

//--- tb/pmcr_top_bench.sv
// Self-checking bench for the power capability word readback block.
module pmcr_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        strap = 1'b0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic [15:0] rdata2;
	logic        ack;
	logic        wake;
	logic        valid;
	logic        ack2;
	logic        wake2;
	logic        valid2;
	logic        ce = 1'b1;
	logic        ce_prev = 1'b1;
	logic [31:0] r;
	logic [31:0] exp_q[$];
	integer      seed = 32'h49EC03BE;
	integer      fails = 0;
	integer      n_checks = 0;
	integer      cycles = 0;

	// Clock at 20 MHz.
	always #25 clk = ~clk;

	// The first instance has no low-state wake, so the strap alone decides bit 3.
	// The second has a data register, so its current field stays zero despite 375 mA.
	pmcr_top #(.AUX_MAX_MA(200), .DEV_INIT_REQ(1'h1), .WAKE_NEEDS_CLK(1'h1)) dut_u (
		.CLK(clk), .RESETN(resetn), .CE(ce), .COLD_WAKE_STRAP_PIN(strap), .CFG_RD(rd),
		.CFG_WR(wr), .CFG_ADDR(addr), .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_ACK(ack),
		.WAKE_FROM_COLD_CAPABLE(wake), .STRAP_VALID(valid));
	pmcr_top #(.AUX_MAX_MA(375), .DATA_REG_IMPL(1'h1)) dut2_u (.CLK(clk), .RESETN(resetn),
		.CE(ce), .COLD_WAKE_STRAP_PIN(strap), .CFG_RD(rd), .CFG_WR(wr), .CFG_ADDR(addr),
		.CFG_WDATA(wdata), .CFG_RDATA(rdata2), .CFG_ACK(ack2),
		.WAKE_FROM_COLD_CAPABLE(wake2), .STRAP_VALID(valid2));

	////////////////////////////////////////////////////////////////////////////
	// Both answers for one request; a read wins over a write.
	function automatic logic [31:0] expect_word(input logic rq, input logic [7:0] a, input logic s);
		if (!rq || a[7:1] != 7'h21)
			return 32'h0;
		return {s, 4'h0, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0, 3'h2,
			s, 4'h0, 1'b0, 1'b0, (s ? 3'h4 : 3'h0), 1'b1, 1'b0, s, 3'h2};
	endfunction

	task automatic check(input string name, input logic [31:0] want, input logic [31:0] seen);
		n_checks++;
		if (seen !== want) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, want, seen);
		end
	endtask

	task automatic conclude();
		$display("Checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Inputs move just after an edge; a request offered while frozen is not taken,
	// so only an enabled request leaves a note for the monitor.
	task automatic request(input logic rq, input logic w, input logic [7:0] a, input logic s,
			input logic c);
		@(posedge clk);
		#1;
		ce = c;
		rd = rq;
		wr = w;
		addr = a;
		wdata = $random(seed);
		if ((rq || w) && c)
			exp_q.push_back(expect_word(rq, a, s));
	endtask

	// Each fresh answer strobe retires the oldest note; a stray strobe counts as a mismatch.
	// A strobe held over by a frozen cycle is the same answer and is not counted again.
	always @(posedge clk) begin
		cycles++;
		check("ack2", {31'h0, ack}, {31'h0, ack2});
		if (ack === 1'b1 && ce_prev) begin
			if (exp_q.size() == 0)
				check("ack", 32'h0, 32'h1);
			else
				check("word", exp_q.pop_front(), {rdata2, rdata});
		end
		ce_prev = ce;
		if (cycles == 1000) begin
			fails++;
			conclude();
		end
	end

	// Two power-on epochs, strap low then high, each with an early read and random traffic.
	initial begin
		for (int e = 0; e < 2; e++) begin
			resetn = 1'b0;
			strap = e[0];
			repeat (2) @(posedge clk);
			#1;
			resetn = 1'b1;
			request(1'b1, 1'b0, 8'h42, 1'b0, 1'b1);
			request(1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
			for (int k = 0; k < 10 && valid !== 1'b1; k++)
				@(posedge clk);
			repeat (2) @(posedge clk);
			#1;
			check("strap", {28'h0, 1'b1, strap, 1'b1, strap}, {28'h0, valid, wake, valid2, wake2});
			for (int i = 0; i < 60; i++) begin
				r = $random(seed);
				request(r[0], r[1], r[2] ? {7'h21, r[3]} : r[15:8], strap, r[4] | r[5]);
			end
			request(1'b0, 1'b0, 8'h00, strap, 1'b1);
			repeat (2) @(posedge clk);
			#1;
			check("pending", 32'h0, 32'(exp_q.size()));
		end
		conclude();
	end
endmodule
